// ---- hdl/multi_board_sync_sequencer.sv ----
// command interpreter that sequences one board inside a synchronized group
//
// Function
// - code 100 makes this board the clock source of the group.
// - code 110 makes this board a clock follower of the source.
// - code 130 on the clock source board arms the whole group; no start before arming.
// - code 10 starts a run; code 11 starts it blocking.
// - a blocking start completes only once the run has stopped.
// - board reports ready at run end; software waits for all boards.
// - code 101 makes this board a trigger source.
// - code 111 makes this board a trigger follower.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module multi_board_sync_sequencer #(
    parameter logic [31:0] RUN_LENGTH_RESET = sync_seq_pkg::RST_RUN_LENGTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic group_arm_in,
    output logic group_arm_out,
    output logic clock_source_role,
    output logic clock_follower_role,
    output logic trigger_source_role,
    output logic trigger_follower_role,
    output logic run_armed,
    output logic run_active,
    output logic run_done_status
);
    logic wr_fire;
    sync_seq_pkg::wr_req_t wr_req;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic timer_start;
    logic timer_busy;
    logic timer_finish;
    logic [31:0] merged;
    logic cmd_write;

    sync_seq_pkg::roles_t roles_r, roles_nxt;
    sync_seq_pkg::run_state_t state_r, state_nxt;
    logic [31:0] cmd_r, cmd_nxt;
    logic [31:0] len_r, len_nxt;
    logic done_r, done_nxt;
    logic block_r, block_nxt;
    logic refused_r, refused_nxt;
    logic arm_out_r, arm_out_nxt;
    logic [31:0] status;

    axil_port u_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr_fire(wr_fire),
        .wr_req(wr_req),
        .wr_hold(block_r),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    run_timer #(
        .CNT_W(sync_seq_pkg::RUN_CNT_W)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(timer_start),
        .length(len_r),
        .busy(timer_busy),
        .finish(timer_finish)
    );

    assign cmd_write = wr_fire && sync_seq_pkg::same_word(wr_req.addr, sync_seq_pkg::OFS_BOARD_COMMAND);
    assign merged = sync_seq_pkg::strb_merge(cmd_r, wr_req.data, wr_req.strb);

    assign group_arm_out = arm_out_r;
    assign clock_source_role = roles_r.clock_source;
    assign clock_follower_role = roles_r.clock_follower;
    assign trigger_source_role = roles_r.trigger_source;
    assign trigger_follower_role = roles_r.trigger_follower;
    assign run_armed = (state_r == sync_seq_pkg::RUN_ARMED);
    assign run_active = timer_busy;
    assign run_done_status = done_r;

    always_comb
    begin
        status = 32'h0000_0000;
        status[sync_seq_pkg::ST_CLOCK_SOURCE] = roles_r.clock_source;
        status[sync_seq_pkg::ST_CLOCK_FOLLOWER] = roles_r.clock_follower;
        status[sync_seq_pkg::ST_TRIGGER_SOURCE] = roles_r.trigger_source;
        status[sync_seq_pkg::ST_TRIGGER_FOLLOWER] = roles_r.trigger_follower;
        status[sync_seq_pkg::ST_ARMED] = (state_r == sync_seq_pkg::RUN_ARMED);
        status[sync_seq_pkg::ST_RUNNING] = timer_busy;
        status[sync_seq_pkg::ST_RUN_DONE] = done_r;
        status[sync_seq_pkg::ST_BLOCKING] = block_r;
        status[sync_seq_pkg::ST_REFUSED] = refused_r;
    end

    always_comb
    begin
        if (sync_seq_pkg::same_word(rd_addr, sync_seq_pkg::OFS_BOARD_COMMAND))
        begin
            rd_data = cmd_r;
        end
        else if (sync_seq_pkg::same_word(rd_addr, sync_seq_pkg::OFS_RUN_STATUS))
        begin
            rd_data = status;
        end
        else if (sync_seq_pkg::same_word(rd_addr, sync_seq_pkg::OFS_RUN_LENGTH))
        begin
            rd_data = len_r;
        end
        else
        begin
            rd_data = 32'h0000_0000;
        end
    end

    always_comb
    begin
        roles_nxt = roles_r;
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        len_nxt = len_r;
        done_nxt = done_r;
        block_nxt = block_r;
        refused_nxt = refused_r;
        arm_out_nxt = 1'b0;
        timer_start = 1'b0;
        if (wr_fire && sync_seq_pkg::same_word(wr_req.addr, sync_seq_pkg::OFS_RUN_LENGTH))
        begin
            len_nxt = sync_seq_pkg::strb_merge(len_r, wr_req.data, wr_req.strb);
        end
        // arm pulse from source board
        // taken before commands so a refusal in the same cycle still sets
        if (group_arm_in && roles_r.clock_follower && state_r != sync_seq_pkg::RUN_ACTIVE)
        begin
            state_nxt = sync_seq_pkg::RUN_ARMED;
            done_nxt = 1'b0;
            refused_nxt = 1'b0;
        end
        if (cmd_write)
        begin
            cmd_nxt = merged;
            // roles are frozen while a run is under way
            case (merged)
                sync_seq_pkg::CMD_CLOCK_SOURCE_ROLE:
                begin
                    if (state_r != sync_seq_pkg::RUN_ACTIVE)
                    begin
                        roles_nxt.clock_source = 1'b1;
                        roles_nxt.clock_follower = 1'b0;
                    end
                    else
                    begin
                        refused_nxt = 1'b1;
                    end
                end
                sync_seq_pkg::CMD_CLOCK_FOLLOWER_ROLE:
                begin
                    if (state_r != sync_seq_pkg::RUN_ACTIVE)
                    begin
                        roles_nxt.clock_follower = 1'b1;
                        roles_nxt.clock_source = 1'b0;
                    end
                    else
                    begin
                        refused_nxt = 1'b1;
                    end
                end
                sync_seq_pkg::CMD_TRIGGER_SOURCE_ROLE:
                begin
                    if (state_r != sync_seq_pkg::RUN_ACTIVE)
                    begin
                        roles_nxt.trigger_source = 1'b1;
                        roles_nxt.trigger_follower = 1'b0;
                    end
                    else
                    begin
                        refused_nxt = 1'b1;
                    end
                end
                sync_seq_pkg::CMD_TRIGGER_FOLLOWER_ROLE:
                begin
                    if (state_r != sync_seq_pkg::RUN_ACTIVE)
                    begin
                        roles_nxt.trigger_follower = 1'b1;
                        roles_nxt.trigger_source = 1'b0;
                    end
                    else
                    begin
                        refused_nxt = 1'b1;
                    end
                end
                sync_seq_pkg::CMD_ARM_GROUP:
                begin
                    if (roles_r.clock_source && state_r != sync_seq_pkg::RUN_ACTIVE)
                    begin
                        state_nxt = sync_seq_pkg::RUN_ARMED;
                        arm_out_nxt = 1'b1;
                        done_nxt = 1'b0;
                        refused_nxt = 1'b0;
                    end
                    else
                    begin
                        refused_nxt = 1'b1;
                    end
                end
                sync_seq_pkg::CMD_RUN, sync_seq_pkg::CMD_RUN_BLOCKING:
                begin
                    if (state_r == sync_seq_pkg::RUN_ARMED)
                    begin
                        state_nxt = sync_seq_pkg::RUN_ACTIVE;
                        timer_start = 1'b1;
                        done_nxt = 1'b0;
                        block_nxt = (merged == sync_seq_pkg::CMD_RUN_BLOCKING);
                    end
                    else
                    begin
                        refused_nxt = 1'b1;
                    end
                end
                default:
                begin
                    refused_nxt = refused_r;
                end
            endcase
        end
        if (timer_finish)
        begin
            // arming is used up; a rerun needs a fresh arm
            state_nxt = sync_seq_pkg::RUN_IDLE;
            done_nxt = 1'b1;
            block_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            roles_r <= '0;
            state_r <= sync_seq_pkg::RUN_IDLE;
            cmd_r <= sync_seq_pkg::RST_BOARD_COMMAND;
            len_r <= RUN_LENGTH_RESET;
            done_r <= 1'b0;
            block_r <= 1'b0;
            refused_r <= 1'b0;
            arm_out_r <= 1'b0;
        end
        else
        begin
            roles_r <= roles_nxt;
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            len_r <= len_nxt;
            done_r <= done_nxt;
            block_r <= block_nxt;
            refused_r <= refused_nxt;
            arm_out_r <= arm_out_nxt;
        end
    end
endmodule // multi_board_sync_sequencer

// ---- hdl/sync_seq_pkg.sv ----
// shared constants and types for the multi-board sync sequencer
package sync_seq_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int RUN_CNT_W = 32;

    localparam logic [31:0] OFS_BOARD_COMMAND = 32'h0000_0000;
    localparam logic [31:0] OFS_RUN_STATUS = 32'h0000_0004;
    localparam logic [31:0] OFS_RUN_LENGTH = 32'h0000_0008;

    localparam logic [31:0] RST_BOARD_COMMAND = 32'h0000_0000;
    localparam logic [31:0] RST_RUN_LENGTH = 32'h0000_03E8;

    localparam logic [31:0] CMD_RUN = 32'h0000_000A;
    localparam logic [31:0] CMD_RUN_BLOCKING = 32'h0000_000B;
    localparam logic [31:0] CMD_CLOCK_SOURCE_ROLE = 32'h0000_0064;
    localparam logic [31:0] CMD_TRIGGER_SOURCE_ROLE = 32'h0000_0065;
    localparam logic [31:0] CMD_CLOCK_FOLLOWER_ROLE = 32'h0000_006E;
    localparam logic [31:0] CMD_TRIGGER_FOLLOWER_ROLE = 32'h0000_006F;
    localparam logic [31:0] CMD_ARM_GROUP = 32'h0000_0082;

    localparam int ST_CLOCK_SOURCE = 0;
    localparam int ST_CLOCK_FOLLOWER = 1;
    localparam int ST_TRIGGER_SOURCE = 2;
    localparam int ST_TRIGGER_FOLLOWER = 3;
    localparam int ST_ARMED = 4;
    localparam int ST_RUNNING = 5;
    localparam int ST_RUN_DONE = 6;
    localparam int ST_BLOCKING = 7;
    localparam int ST_REFUSED = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] strb;
    } wr_req_t;

    typedef struct packed {
        logic clock_source;
        logic clock_follower;
        logic trigger_source;
        logic trigger_follower;
    } roles_t;

    typedef enum logic [1:0] {RUN_IDLE, RUN_ARMED, RUN_ACTIVE} run_state_t;

    function automatic logic same_word(input logic [31:0] a, input logic [31:0] ofs);
        return a[31:2] == ofs[31:2];
    endfunction

    function automatic logic addr_mapped(input logic [31:0] a);
        return same_word(a, OFS_BOARD_COMMAND) || same_word(a, OFS_RUN_STATUS) || same_word(a, OFS_RUN_LENGTH);
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                m[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return m;
    endfunction
endpackage

// ---- hdl/axil_port.sv ----
// axi4-lite slave front end: holds write address and data, answers reads
`timescale 1ns/1ps
module axil_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_fire,
    output sync_seq_pkg::wr_req_t wr_req,
    input wire logic wr_hold,
    output logic [31:0] rd_addr,
    input wire logic [31:0] rd_data
);
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [31:0] aw_addr_r, aw_addr_nxt, w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic wr_pend_r, wr_pend_nxt, bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    assign awready = !aw_full_r;
    assign wready = !w_full_r;
    assign arready = !rvalid_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign rd_addr = araddr;
    // one write at a time; the next waits for the response to drain
    assign wr_fire = aw_full_r && w_full_r && !wr_pend_r && !bvalid_r;
    assign wr_req = '{addr: aw_addr_r, data: w_data_r, strb: w_strb_r};

    always_comb
    begin
        aw_full_nxt = aw_full_r;
        aw_addr_nxt = aw_addr_r;
        w_full_nxt = w_full_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        wr_pend_nxt = wr_pend_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (awvalid && !aw_full_r)
        begin
            aw_full_nxt = 1'b1;
            aw_addr_nxt = awaddr;
        end
        if (wvalid && !w_full_r)
        begin
            w_full_nxt = 1'b1;
            w_data_nxt = wdata;
            w_strb_nxt = wstrb;
        end
        if (wr_fire)
        begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            wr_pend_nxt = 1'b1;
            bresp_nxt = sync_seq_pkg::addr_mapped(aw_addr_r) ? sync_seq_pkg::RESP_OKAY : sync_seq_pkg::RESP_DECERR;
        end
        if (wr_pend_r && !wr_hold)
        begin
            wr_pend_nxt = 1'b0;
            bvalid_nxt = 1'b1;
        end
        if (bvalid_r && bready)
        begin
            bvalid_nxt = 1'b0;
        end
        if (arvalid && !rvalid_r)
        begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_data;
            rresp_nxt = sync_seq_pkg::addr_mapped(araddr) ? sync_seq_pkg::RESP_OKAY : sync_seq_pkg::RESP_DECERR;
        end
        else if (rvalid_r && rready)
        begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            aw_addr_r <= 32'h0000_0000;
            w_full_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            wr_pend_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'h0;
        end
        else
        begin
            aw_full_r <= aw_full_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_full_r <= w_full_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            wr_pend_r <= wr_pend_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end
endmodule // axil_port

// ---- hdl/run_timer.sv ----
// counts down the length of one run and flags its end
`timescale 1ns/1ps
module run_timer #(
    parameter int CNT_W = sync_seq_pkg::RUN_CNT_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic [CNT_W-1:0] length,
    output logic busy,
    output logic finish
);
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;

    assign busy = busy_r;
    assign finish = busy_r && (cnt_r == CNT_W'(1));

    always_comb
    begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        if (start)
        begin
            busy_nxt = 1'b1;
            // zero length would wrap and run 2^32 cycles; treat it as one cycle
            cnt_nxt = (length == '0) ? CNT_W'(1) : length;
        end
        else if (finish)
        begin
            busy_nxt = 1'b0;
        end
        else if (busy_r)
        begin
            cnt_nxt = cnt_r - CNT_W'(1);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end
endmodule // run_timer

// ---- dv/peer_board.sv ----
// model of the peer clock source board
`timescale 1ns/1ps
module peer_board (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic arm_req,
    input wire logic [3:0] arm_dly,
    output logic group_arm
);
    logic [4:0] cnt_r, cnt_nxt;
    logic arm_nxt;
    always_comb
    begin
        cnt_nxt = cnt_r;
        arm_nxt = 1'h0;
        if (arm_req)
            cnt_nxt = {1'h0, arm_dly} + 5'h1;
        else if (cnt_r != 5'h0)
        begin
            cnt_nxt = cnt_r - 5'h1;
            arm_nxt = (cnt_r == 5'h1);
        end
    end
    always_ff @(posedge aclk)
    begin
        cnt_r <= aresetn ? cnt_nxt : 5'h0;
        group_arm <= aresetn ? arm_nxt : 1'h0;
    end
endmodule // peer_board

// ---- dv/seq_properties.sv ----
// port checks of the sequencer
`timescale 1ns/1ps
module seq_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic group_arm_in,
    input wire logic group_arm_out,
    input wire logic clock_source_role,
    input wire logic clock_follower_role,
    input wire logic trigger_source_role,
    input wire logic trigger_follower_role,
    input wire logic run_armed,
    input wire logic run_active,
    input wire logic run_done_status
);
    logic blk_r, blk_nxt;
    always_comb
    begin
        blk_nxt = blk_r;
        if (s_axi_wvalid && s_axi_wready)
            blk_nxt = (s_axi_wdata == sync_seq_pkg::CMD_RUN_BLOCKING);
    end
    always_ff @(posedge aclk)
        blk_r <= aresetn ? blk_nxt : 1'h0;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    arm_pulse_a: assert property (group_arm_out |=> !group_arm_out)
        else $error("arm pulse too long");
    arm_source_a: assert property (group_arm_out |-> clock_source_role)
        else $error("arm from non source");
    clock_roles_a: assert property (!(clock_source_role && clock_follower_role))
        else $error("both clock roles");
    trig_roles_a: assert property (!(trigger_source_role && trigger_follower_role))
        else $error("both trigger roles");
    start_armed_a: assert property ($rose(run_active) |-> $past(run_armed) && !run_armed)
        else $error("start without arm");
    done_end_a: assert property ($fell(run_active) |-> run_done_status)
        else $error("no ready at run end");
    busy_ready_a: assert property (run_active |-> !run_done_status)
        else $error("ready while running");
    block_resp_a: assert property ($rose(s_axi_bvalid) && blk_r |-> !run_active)
        else $error("blocking answer early");
    follow_arm_a: assert property (group_arm_in && clock_follower_role && !run_active |=> run_armed)
        else $error("follower not armed");
endmodule // seq_properties

// ---- dv/tb_multi_board_sync_sequencer.sv ----
// self-checking bench for the sync sequencer
`timescale 1ns/1ps
module tb_multi_board_sync_sequencer;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, arm_req = 1'h0;
    logic [3:0] arm_dly = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, len, ukn;
    logic group_arm_in, group_arm_out, clock_source_role, clock_follower_role;
    logic trigger_source_role, trigger_follower_role, run_armed, run_active, run_done_status;
    // lfsr starts at 7497
    logic [15:0] rnd = 16'h1D49;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int n_mismatch = 0, samples_checked = 0, cycles = 0, i, n_arm = 0;

    always #2 aclk = ~aclk;

    multi_board_sync_sequencer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .group_arm_in, .group_arm_out, .clock_source_role,
        .clock_follower_role, .trigger_source_role, .trigger_follower_role, .run_armed,
        .run_active, .run_done_status);

    peer_board peer (.aclk, .aresetn, .arm_req, .arm_dly, .group_arm(group_arm_in));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic cmp_bus(input string nm, input logic [33:0] e, input logic [33:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic pin(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s exp %b got %b", nm, e, g);
        end
    endtask

    // offers address and data together, waits for the answer
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, tb;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        tb = 1'h0;
        while (!tb)
        begin
            // negedge value is what the next edge samples
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (tb) s_axi_bready <= 1'h0;
        end
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tr;
        rq.push_back({r, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        tr = 1'h0;
        while (!tr)
        begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'h0;
            if (tr) s_axi_rready <= 1'h0;
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(negedge aclk)
    begin
        if (group_arm_out === 1'h1) n_arm++;
        if (s_axi_bvalid && s_axi_bready)
            cmp_bus("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
        if (s_axi_rvalid && s_axi_rready)
            cmp_bus("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    end

    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch++;
            results;
        end
    end

    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        rd(sync_seq_pkg::OFS_BOARD_COMMAND, sync_seq_pkg::RST_BOARD_COMMAND, 2'h0);
        rd(sync_seq_pkg::OFS_RUN_LENGTH, sync_seq_pkg::RST_RUN_LENGTH, 2'h0);
        wr(sync_seq_pkg::OFS_BOARD_COMMAND, sync_seq_pkg::CMD_RUN, 2'h0);
        @(negedge aclk);
        pin("active", 1'h0, run_active);
        rd(sync_seq_pkg::OFS_RUN_STATUS, 32'h100, 2'h0);
        $display("test start refusal done");
        rnd = lfsr(rnd);
        ukn = {24'h1, rnd[7:0]};
        wr(sync_seq_pkg::OFS_BOARD_COMMAND, sync_seq_pkg::CMD_CLOCK_SOURCE_ROLE, 2'h0);
        wr(sync_seq_pkg::OFS_BOARD_COMMAND, sync_seq_pkg::CMD_TRIGGER_FOLLOWER_ROLE, 2'h0);
        wr(sync_seq_pkg::OFS_BOARD_COMMAND, ukn, 2'h0);
        rd(sync_seq_pkg::OFS_BOARD_COMMAND, ukn, 2'h0);
        rd(sync_seq_pkg::OFS_RUN_STATUS, 32'h109, 2'h0);
        wr(sync_seq_pkg::OFS_BOARD_COMMAND, sync_seq_pkg::CMD_TRIGGER_SOURCE_ROLE, 2'h0);
        @(negedge aclk);
        pin("trig_src", 1'h1, trigger_source_role);
        pin("trig_fol", 1'h0, trigger_follower_role);
        $display("test roles done");
        rnd = lfsr(rnd);
        len = {29'h0, rnd[2:0]} + 32'h4;
        wr(sync_seq_pkg::OFS_RUN_LENGTH, len, 2'h0);
        wr(sync_seq_pkg::OFS_BOARD_COMMAND, sync_seq_pkg::CMD_ARM_GROUP, 2'h0);
        rd(sync_seq_pkg::OFS_RUN_STATUS, 32'h15, 2'h0);
        wr(sync_seq_pkg::OFS_BOARD_COMMAND, sync_seq_pkg::CMD_RUN, 2'h0);
        @(negedge aclk);
        pin("active", 1'h1, run_active);
        pin("ready", 1'h0, run_done_status);
        for (i = 0; i < 60 && !run_done_status; i++) @(negedge aclk);
        cmp_bus("run_len", 34'(len - 32'h2), 34'(i));
        pin("ready", 1'h1, run_done_status);
        pin("active", 1'h0, run_active);
        wr(sync_seq_pkg::OFS_BOARD_COMMAND, sync_seq_pkg::CMD_ARM_GROUP, 2'h0);
        wr(sync_seq_pkg::OFS_BOARD_COMMAND, sync_seq_pkg::CMD_RUN_BLOCKING, 2'h0);
        @(negedge aclk);
        pin("active", 1'h0, run_active);
        pin("ready", 1'h1, run_done_status);
        $display("test runs done");
        wr(sync_seq_pkg::OFS_BOARD_COMMAND, sync_seq_pkg::CMD_CLOCK_FOLLOWER_ROLE, 2'h0);
        @(posedge aclk);
        arm_dly <= rnd[6:3];
        arm_req <= 1'h1;
        @(posedge aclk);
        arm_req <= 1'h0;
        for (i = 0; i < 40 && !run_armed; i++) @(negedge aclk);
        pin("armed", 1'h1, run_armed);
        pin("clk_fol", 1'h1, clock_follower_role);
        pin("clk_src", 1'h0, clock_source_role);
        wr(sync_seq_pkg::OFS_BOARD_COMMAND, sync_seq_pkg::CMD_ARM_GROUP, 2'h0);
        rd(sync_seq_pkg::OFS_RUN_STATUS, 32'h116, 2'h0);
        cmp_bus("arm_out", 34'h2, 34'(n_arm));
        $display("test follower done");
        wr(32'h10, 32'h0, sync_seq_pkg::RESP_DECERR);
        rd(32'h10, 32'h0, sync_seq_pkg::RESP_DECERR);
        $display("test unmapped done");
        results;
    end
endmodule // tb_multi_board_sync_sequencer

bind multi_board_sync_sequencer seq_properties chk (.aclk, .aresetn, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .group_arm_in, .group_arm_out, .clock_source_role,
    .clock_follower_role, .trigger_source_role, .trigger_follower_role, .run_armed,
    .run_active, .run_done_status);
